/* common/gdc_map.svh */
// register offsets, opcodes, field positions, sizes and mode codes for the command unit
`ifndef GDC_MAP_SVH
`define GDC_MAP_SVH
`define GDC_OP_SET_ORIGIN   6'h01
`define GDC_OP_PREG_WRITE   6'h02
`define GDC_OP_PREG_READ    6'h03
`define GDC_OP_PTN_WRITE    6'h06
`define GDC_OP_PTN_READ     6'h07
`define GDC_OP_DMA_READ     6'h09
`define GDC_OP_DMA_WRITE    6'h0A
`define GDC_OP_DMA_MODIFY   6'h0B
`define GDC_OP_MSB          15
`define GDC_OP_LSB          10
`define GDC_RN_MSB          4
`define GDC_PRA_MSB         3
`define GDC_MM_MSB          1
`define GDC_SCR_MSB         15
`define GDC_SCR_LSB         14
`define GDC_HI_MSB          7
`define GDC_LOW_MSB         15
`define GDC_LOW_LSB         4
`define GDC_DOT_MSB         3
`define GDC_PREG_COUNT      32
`define GDC_PTN_DEPTH       16
`define GDC_MASK_REG        5'h00
`define GDC_MM_REPLACE      2'h0
`define GDC_MM_OR           2'h1
`define GDC_MM_AND          2'h2
`define GDC_MM_EOR          2'h3
`define GDC_SCR_UPPER       2'h0
`define GDC_SCR_BASE        2'h1
`define GDC_SCR_LOWER       2'h2
`define GDC_SCR_WINDOW      2'h3
`endif

/* common/gdc_pkg.sv */
// types shared by the command unit
package gdc_pkg;
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_PAR1  = 9'h002,
		ST_PAR2  = 9'h004,
		ST_PTNW  = 9'h008,
		ST_PTNR  = 9'h010,
		ST_DREQ  = 9'h020,
		ST_FBRD  = 9'h040,
		ST_FBWR  = 9'h080,
		ST_DONE  = 9'h100
	} gdc_state_t;
	typedef enum logic [1:0] {
		SCR_UPPER  = 2'h0,
		SCR_BASE   = 2'h1,
		SCR_LOWER  = 2'h2,
		SCR_WINDOW = 2'h3
	} gdc_screen_t;
endpackage : gdc_pkg

/* rtl/gdc_axis_walk.sv */
// one axis of a rectangle scan: extent from a signed word, direction and last-word flag
`timescale 1ns/1ps
module gdc_axis_walk
	import gdc_pkg::*;
(
	input  wire logic        sys_clk,   // system clock
	input  wire logic        srst,      // synchronous reset
	input  wire logic        load,      // take a new extent
	input  wire logic [15:0] extentIn,  // signed extent parameter
	input  wire logic        step,      // advance one word
	output logic             negDir,    // scan runs backwards
	output logic             atLast     // current position is the last
);
	logic [15:0] remain_r;
	// width is |param|+1: remaining steps equals |param|
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			remain_r <= 16'h0000;
			negDir   <= 1'b0;
		end else if (load) begin
			negDir   <= extentIn[15];
			remain_r <= extentIn[15] ? 16'(-extentIn) : extentIn;
		end else if (step) begin
			remain_r <= (remain_r == 16'h0000) ? 16'h0000 : 16'(remain_r - 16'h0001);
		end
	end
	assign atLast = (remain_r == 16'h0000);
endmodule : gdc_axis_walk

/* rtl/gdc_cmd_unit.sv */
// command interpreter: origin, parameter registers, pattern memory, dma block moves
`timescale 1ns/1ps
`include "gdc_map.svh"
module gdc_cmd_unit
	import gdc_pkg::*;
(
	input  wire logic        sys_clk,      // system clock
	input  wire logic        srst,         // synchronous reset
	input  wire logic        byteHost,     // host bus is 8 bits wide
	input  wire logic [15:0] cmdData,      // command or parameter word
	input  wire logic        cmdValid,     // word offered
	output logic             cmdReady,     // word accepted this cycle
	input  wire logic [1:0]  rwScreenIn,   // read-write pointer screen preset
	input  wire logic [19:0] rwAddrIn,     // read-write pointer address preset
	input  wire logic        rwLoad,       // load read-write pointer preset
	output logic [15:0]      fifoData,     // word pushed to read FIFO
	output logic             fifoPush,     // push strobe
	input  wire logic        fifoFull,     // read FIFO cannot take a word
	output logic             dmaReq,       // request to external dma controller
	input  wire logic        dmaAckPin,    // acknowledge, async pin
	input  wire logic [15:0] dmaWrData,    // word from host memory
	output logic [15:0]      dmaRdData,    // word toward host memory
	output logic [19:0]      fbAddr,       // frame buffer word address
	output logic [1:0]       fbScreen,     // frame buffer screen
	output logic             fbRead,       // frame buffer read strobe
	output logic             fbWrite,      // frame buffer write strobe
	output logic [15:0]      fbWrData,     // frame buffer write word
	input  wire logic [15:0] fbRdData,     // frame buffer read word, next cycle
	output logic             dmaMode,      // dma transfer mode active
	output logic             busy,         // command in progress
	output logic [1:0]       drawScreen,   // origin screen
	output logic [19:0]      drawAddr,     // drawing pointer word address
	output logic [3:0]       drawDot,      // drawing pointer dot position
	output logic [19:0]      curPointer    // current pointer
);
	gdc_state_t  state_r;
	logic [5:0]  op_r;
	logic [4:0]  field_r;
	logic [15:0] par1_r;
	logic [15:0] count_r;
	logic [3:0]  ptnAddr_r;
	logic        ptnLowByte_r;
	logic [15:0] ptnHold_r;
	logic [15:0] preg_r [`GDC_PREG_COUNT];
	logic [15:0] ptnMem_r [`GDC_PTN_DEPTH];
	logic [19:0] rwAddr_r;
	logic [1:0]  rwScreen_r;
	logic [19:0] lineStart_r;
	logic        ackMeta_r, ackSync_r, ackOld_r;
	logic        ackRise;
	logic        xLoad, yLoad, xStep, yStep, xNeg, yNeg, xLast, yLast;
	logic        wordTake;
	logic        fbRdValid_r;
	logic [15:0] memWidth;
	logic [15:0] maskWord;
	logic [15:0] mergeWord;

	assign wordTake = cmdValid & cmdReady;
	assign memWidth = preg_r[5'h01];  // row pitch in words for vertical steps
	assign maskWord = preg_r[`GDC_MASK_REG];
	assign ackRise  = ackSync_r & ~ackOld_r;

	// acknowledge pin: two flops, then edge detect on the second
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ackMeta_r <= 1'b0;
			ackSync_r <= 1'b0;
			ackOld_r  <= 1'b0;
		end else begin
			ackMeta_r <= dmaAckPin;
			ackSync_r <= ackMeta_r;
			ackOld_r  <= ackSync_r;
		end
	end

	// rectangle extents, one walker per axis
	assign xLoad = (state_r == ST_PAR1) & wordTake & op_r[3];
	assign yLoad = (state_r == ST_PAR2) & wordTake & op_r[3];
	gdc_axis_walk uXWalk (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.load     (xLoad | yStep),
		.extentIn (xLoad ? cmdData : par1_r),
		.step     (xStep),
		.negDir   (xNeg),
		.atLast   (xLast)
	);
	gdc_axis_walk uYWalk (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.load     (yLoad),
		.extentIn (cmdData),
		.step     (yStep),
		.negDir   (yNeg),
		.atLast   (yLast)
	);

	// modify merge: mode picks operation, mask limits changed bits
	always_comb begin
		logic [15:0] opWord;
		opWord = dmaWrData;
		unique case (field_r[`GDC_MM_MSB:0])
			`GDC_MM_REPLACE: opWord = dmaWrData;
			`GDC_MM_OR:      opWord = fbRdData | dmaWrData;
			`GDC_MM_AND:     opWord = fbRdData & dmaWrData;
			`GDC_MM_EOR:     opWord = fbRdData ^ dmaWrData;
		endcase
		mergeWord = (opWord & maskWord) | (fbRdData & ~maskWord);
	end

	// word completes on its frame buffer write, or for a dma read when acked in request phase
	logic wordDone;
	assign wordDone = (state_r == ST_FBWR) ||
		((state_r == ST_DREQ) && ackRise && op_r == `GDC_OP_DMA_READ);
	assign xStep = wordDone & ~xLast;
	assign yStep = wordDone & xLast & ~yLast;

	// command sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r      <= ST_IDLE;
			op_r         <= 6'h00;
			field_r      <= 5'h00;
			par1_r       <= 16'h0000;
			count_r      <= 16'h0000;
			ptnAddr_r    <= 4'h0;
			ptnLowByte_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: if (wordTake) begin
					op_r         <= cmdData[`GDC_OP_MSB:`GDC_OP_LSB];
					field_r      <= cmdData[`GDC_RN_MSB:0];
					ptnAddr_r    <= cmdData[`GDC_PRA_MSB:0];
					ptnLowByte_r <= 1'b0;
					state_r      <= (cmdData[`GDC_OP_MSB:`GDC_OP_LSB] == `GDC_OP_PREG_READ)
						? ST_DONE : ST_PAR1;
				end
				ST_PAR1: if (wordTake) begin
					par1_r  <= cmdData;
					count_r <= cmdData;
					unique case (op_r)
						`GDC_OP_PREG_WRITE: state_r <= ST_DONE;
						`GDC_OP_PTN_WRITE:  state_r <= (cmdData == 16'h0000) ? ST_IDLE : ST_PTNW;
						`GDC_OP_PTN_READ:   state_r <= (cmdData == 16'h0000) ? ST_IDLE : ST_PTNR;
						default:            state_r <= ST_PAR2;
					endcase
				end
				ST_PAR2: if (wordTake) begin
					state_r <= op_r[3] ? ST_DREQ : ST_IDLE;
				end
				ST_PTNW: if (wordTake) begin
					count_r <= 16'(count_r - 16'h0001);
					if (byteHost)
						ptnLowByte_r <= ~ptnLowByte_r;
					if (!byteHost || ptnLowByte_r)
						ptnAddr_r <= 4'(ptnAddr_r + 4'h1);
					if (count_r == 16'h0001)
						state_r <= ST_IDLE;
				end
				ST_PTNR: if (!fifoFull) begin
					count_r <= 16'(count_r - 16'h0001);
					if (byteHost)
						ptnLowByte_r <= ~ptnLowByte_r;
					if (!byteHost || ptnLowByte_r)
						ptnAddr_r <= 4'(ptnAddr_r + 4'h1);
					if (count_r == 16'h0001 || (byteHost && count_r == 16'h0000))
						state_r <= ST_IDLE;
				end
				ST_DREQ: if (ackRise) begin
					if (op_r == `GDC_OP_DMA_READ)
						state_r <= (xLast && yLast) ? ST_IDLE : ST_FBRD;
					else
						state_r <= ST_FBRD;
				end
				ST_FBRD: if (op_r == `GDC_OP_DMA_READ)
					state_r <= ST_DREQ;
				else if (fbRdValid_r)
					state_r <= ST_FBWR;
				ST_FBWR: state_r <= (xLast && yLast) ? ST_IDLE : ST_DREQ;
				ST_DONE: if (!(op_r == `GDC_OP_PREG_READ && fifoFull))
					state_r <= ST_IDLE;
			endcase
		end
	end

	// parameter registers and the origin command
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < `GDC_PREG_COUNT; i++)
				preg_r[i] <= 16'h0000;
			drawScreen <= `GDC_SCR_UPPER;
			drawAddr   <= 20'h00000;
			drawDot    <= 4'h0;
			curPointer <= 20'h00000;
		end else begin
			if (state_r == ST_PAR1 && wordTake && op_r == `GDC_OP_PREG_WRITE)
				preg_r[field_r] <= cmdData;
			if (state_r == ST_PAR2 && wordTake && op_r == `GDC_OP_SET_ORIGIN) begin
				drawScreen <= par1_r[`GDC_SCR_MSB:`GDC_SCR_LSB];
				drawAddr   <= {par1_r[`GDC_HI_MSB:0], cmdData[`GDC_LOW_MSB:`GDC_LOW_LSB]};
				drawDot    <= cmdData[`GDC_DOT_MSB:0];
				curPointer <= 20'h00000;
			end
		end
	end

	// pattern memory writes; word assembled from two bytes on a byte host
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ptnHold_r <= 16'h0000;
		end else if (state_r == ST_PTNW && wordTake) begin
			if (byteHost && !ptnLowByte_r)
				ptnHold_r <= {cmdData[7:0], 8'h00};
			else if (byteHost)
				ptnMem_r[ptnAddr_r] <= {ptnHold_r[15:8], cmdData[7:0]};
			else
				ptnMem_r[ptnAddr_r] <= cmdData;
		end
	end

	// read FIFO pushes from register read and pattern read
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fifoPush <= 1'b0;
			fifoData <= 16'h0000;
		end else begin
			fifoPush <= 1'b0;
			if (state_r == ST_DONE && op_r == `GDC_OP_PREG_READ && !fifoFull) begin
				fifoPush <= 1'b1;
				fifoData <= preg_r[field_r];
			end else if (state_r == ST_PTNR && !fifoFull) begin
				fifoPush <= 1'b1;
				fifoData <= !byteHost ? ptnMem_r[ptnAddr_r] :
					ptnLowByte_r ? {8'h00, ptnMem_r[ptnAddr_r][7:0]}
					             : {8'h00, ptnMem_r[ptnAddr_r][15:8]};
			end
		end
	end

	// read-write pointer walk; ends on the rectangle's last word
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rwAddr_r    <= 20'h00000;
			rwScreen_r  <= `GDC_SCR_UPPER;
			lineStart_r <= 20'h00000;
		end else if (rwLoad && state_r == ST_IDLE) begin
			rwAddr_r    <= rwAddrIn;
			rwScreen_r  <= rwScreenIn;
			lineStart_r <= rwAddrIn;
		end else if (state_r == ST_PAR2 && wordTake && op_r[3]) begin
			lineStart_r <= rwAddr_r;
		end else if (xStep) begin
			rwAddr_r <= xNeg ? 20'(rwAddr_r - 20'h1) : 20'(rwAddr_r + 20'h1);
		end else if (yStep) begin
			rwAddr_r    <= yNeg ? 20'(lineStart_r - {4'h0, memWidth})
			                    : 20'(lineStart_r + {4'h0, memWidth});
			lineStart_r <= yNeg ? 20'(lineStart_r - {4'h0, memWidth})
			                    : 20'(lineStart_r + {4'h0, memWidth});
		end
		// last word leaves no step, so pointer rests on the end address
	end

	// frame buffer address and screen follow the pointer; idle they show the end address
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fbAddr   <= 20'h00000;
			fbScreen <= `GDC_SCR_UPPER;
		end else begin
			fbAddr   <= rwAddr_r;
			fbScreen <= rwScreen_r;
		end
	end

	// frame buffer strobes; the read word comes back one cycle after the strobe,
	// so a write waits for it instead of merging whatever the bus last held
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fbRead      <= 1'b0;
			fbRdValid_r <= 1'b0;
			fbWrite     <= 1'b0;
			fbWrData    <= 16'h0000;
		end else begin
			// read ahead so the word is ready before the first acknowledge
			fbRead      <= (state_r == ST_PAR2 && wordTake && op_r == `GDC_OP_DMA_READ) ||
				(state_r == ST_FBRD && op_r == `GDC_OP_DMA_READ) ||
				(state_r == ST_DREQ && ackRise && op_r != `GDC_OP_DMA_READ);
			fbRdValid_r <= fbRead;
			fbWrite     <= (state_r == ST_FBRD) && fbRdValid_r &&
				(op_r != `GDC_OP_DMA_READ);
			fbWrData    <= (op_r == `GDC_OP_DMA_MODIFY) ? mergeWord : dmaWrData;
		end
	end

	// dma side: the outgoing word is latched from the returned read before the
	// acknowledge rises, and the request drops once the acknowledge edge is seen
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dmaReq    <= 1'b0;
			dmaRdData <= 16'h0000;
		end else begin
			if (fbRdValid_r && op_r == `GDC_OP_DMA_READ)
				dmaRdData <= fbRdData;
			// an acknowledge still high from the last word must not start a new one
			dmaReq <= (state_r == ST_DREQ) && !ackRise && !ackSync_r;
		end
	end

	// status levels and the host word handshake
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dmaMode  <= 1'b0;
			busy     <= 1'b0;
			cmdReady <= 1'b0;
		end else begin
			dmaMode <= (state_r == ST_DREQ) || (state_r == ST_FBRD) || (state_r == ST_FBWR);
			busy    <= (state_r != ST_IDLE);
			// ready pulses at most every other cycle, so one offered word is
			// never taken twice; during dma the host is held off
			cmdReady <= !cmdReady && (state_r == ST_IDLE || state_r == ST_PAR1 ||
				state_r == ST_PAR2 || state_r == ST_PTNW);
		end
	end
endmodule : gdc_cmd_unit

/* bench/gdc_cmd_props.sv */
// port assertions for the command unit
`timescale 1ns/1ps
module gdc_cmd_props
	import gdc_pkg::*;
(
	input wire logic sys_clk,   // clock
	input wire logic srst,      // reset
	input wire logic cmdReady,  // word taken
	input wire logic dmaReq,    // dma request
	input wire logic dmaAckPin, // dma ack
	input wire logic fbRead,    // fb read
	input wire logic fbWrite,   // fb write
	input wire logic dmaMode,   // dma mode
	input wire logic busy       // busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// handshake: the ack synchroniser costs up to three cycles
	req_in_mode_a: assert property (dmaReq |-> dmaMode)
		else $error("request outside dma mode");
	req_hold_a: assert property (dmaReq && !dmaAckPin && !$past(dmaAckPin)
		&& !$past(dmaAckPin, 2) |=> dmaReq) else $error("request dropped early");
	req_drop_a: assert property ($rose(dmaAckPin) && dmaReq |-> ##[1:5] !dmaReq)
		else $error("request not retired");
	mode_busy_a: assert property (dmaMode |-> busy)
		else $error("dma mode while idle");
	no_take_a: assert property (dmaMode |-> !cmdReady)
		else $error("word taken in dma mode");
	ready_gap_a: assert property (cmdReady |=> !cmdReady)
		else $error("ready twice in a row");
	strobe_excl_a: assert property (!(fbRead && fbWrite))
		else $error("read and write together");
	fb_busy_a: assert property (fbRead || fbWrite |-> busy || $past(busy))
		else $error("frame access while idle");
	cover property ($rose(dmaMode));
	cover property (fbRead ##[1:3] fbWrite);
	cover property ($rose(dmaAckPin) ##[1:5] $fell(dmaReq));
endmodule : gdc_cmd_props
bind gdc_cmd_unit gdc_cmd_props props_u (.sys_clk(sys_clk), .srst(srst), .cmdReady(cmdReady),
	.dmaReq(dmaReq), .dmaAckPin(dmaAckPin), .fbRead(fbRead), .fbWrite(fbWrite),
	.dmaMode(dmaMode), .busy(busy));

/* bench/gdc_dma_partner.sv */
// dma controller stand-in: one ack per request, serves and collects words
`timescale 1ns/1ps
module gdc_dma_partner
	import gdc_pkg::*;
(
	input  wire logic        sys_clk,   // clock
	input  wire logic        srst,      // reset
	input  wire logic        slow,      // late ack
	input  wire logic        dmaReq,    // request
	input  wire logic [15:0] dmaRdData, // word to memory
	output logic             dmaAckPin, // ack
	output logic [15:0]      dmaWrData, // word from memory
	output logic [15:0]      rdWord,    // word taken
	output logic             rdTake     // transfer done
);
	logic [7:0] cnt_r; // transfers since reset
	logic [3:0] dly_r; // cycles waited
	// ack held until the request falls; data garbled while waiting
	always_ff @(posedge sys_clk) begin
		rdTake <= 1'b0;
		if (srst) begin
			dmaAckPin <= 1'b0;
			dmaWrData <= 16'h0000;
			rdWord <= 16'h0000;
			cnt_r <= 8'h00;
			dly_r <= 4'h0;
		end else if (dmaAckPin && !dmaReq) begin
			dmaAckPin <= 1'b0;
			rdWord <= dmaRdData;
			rdTake <= 1'b1;
			cnt_r <= cnt_r + 8'h01;
		end else if (dmaReq && !dmaAckPin) begin
			dmaWrData <= ~dmaWrData;
			dly_r <= dly_r + 4'h1;
			if (dly_r >= (slow ? 4'h6 : 4'h1)) begin
				dmaAckPin <= 1'b1;
				dly_r <= 4'h0;
				dmaWrData <= {cnt_r, ~cnt_r} ^ 16'h5A3C;
			end
		end
	end
endmodule : gdc_dma_partner

/* bench/test_graphics_register_dma_command_unit.sv */
// bench: origin, parameters, pattern memory and dma moves on a memory model
`timescale 1ns/1ps
module test_graphics_register_dma_command_unit;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        byteHost = 1'b0;
	logic        cmdValid = 1'b0;
	logic        rwLoad = 1'b0;
	logic        fifoFull = 1'b0;
	logic        slow = 1'b0;
	logic [1:0]  rwScreenIn = 2'h1;
	logic [15:0] cmdData = 16'h0000;
	logic [15:0] fbRdData = 16'h0000;
	logic [19:0] rwAddrIn = 20'h00000;
	logic [15:0] fifoData, dmaWrData, dmaRdData, fbWrData, rdWord;
	logic        cmdReady, fifoPush, dmaReq, dmaAckPin, fbRead, fbWrite, dmaMode, busy, rdTake;
	logic [19:0] fbAddr, drawAddr, curPointer;
	logic [1:0]  fbScreen, drawScreen;
	logic [3:0]  drawDot;
	logic [15:0] fbMem [0:255];
	logic [15:0] pushQ [$];
	logic [15:0] takeQ [$];
	int          mismatches = 0;
	int          cmp_count = 0;
	int          xfers = 0;
	always #4 sys_clk = ~sys_clk;
	gdc_cmd_unit dut_u (.sys_clk(sys_clk), .srst(srst), .byteHost(byteHost), .cmdData(cmdData),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .rwScreenIn(rwScreenIn),
		.rwAddrIn(rwAddrIn),
		.rwLoad(rwLoad), .fifoData(fifoData), .fifoPush(fifoPush), .fifoFull(fifoFull),
		.dmaReq(dmaReq), .dmaAckPin(dmaAckPin), .dmaWrData(dmaWrData), .dmaRdData(dmaRdData),
		.fbAddr(fbAddr), .fbScreen(fbScreen), .fbRead(fbRead), .fbWrite(fbWrite),
		.fbWrData(fbWrData), .fbRdData(fbRdData), .dmaMode(dmaMode), .busy(busy),
		.drawScreen(drawScreen), .drawAddr(drawAddr), .drawDot(drawDot), .curPointer(curPointer));
	gdc_dma_partner dma_u (.sys_clk(sys_clk), .srst(srst), .slow(slow), .dmaReq(dmaReq),
		.dmaRdData(dmaRdData), .dmaAckPin(dmaAckPin), .dmaWrData(dmaWrData), .rdWord(rdWord),
		.rdTake(rdTake));
	// frame buffer model and collectors; idle read data is garbled
	always @(posedge sys_clk) begin
		if (fifoPush)
			pushQ.push_back(fifoData);
		if (rdTake)
			takeQ.push_back(rdWord);
		xfers <= xfers + int'(rdTake);
		if (fbWrite)
			fbMem[fbAddr[7:0]] <= fbWrData;
		if (fbRead || fbWrite)
			chk("fbScreen", 20'(rwScreenIn), 20'(fbScreen));
		fbRdData <= fbRead ? fbMem[fbAddr[7:0]] : ~fbRdData;
	end
	task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
		cmp_count++;
		if (exp !== got) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wrap_up();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// word held until ready is sampled high
	task automatic put(logic [15:0] w);
		int i;
		@(posedge sys_clk);
		cmdData <= w;
		cmdValid <= 1'b1;
		for (i = 0; i < 99; i++) begin
			@(posedge sys_clk);
			if (cmdReady === 1'b1)
				break;
		end
		cmdValid <= 1'b0;
		if (i == 99) begin
			chk("cmdReady", 1, 0);
			wrap_up();
		end
	endtask : put
	task automatic idle();
		int i;
		repeat (3) @(posedge sys_clk);
		for (i = 0; i < 3000 && (busy !== 1'b0 || dmaMode !== 1'b0); i++)
			@(posedge sys_clk);
		if (i == 3000) begin
			chk("idle", 0, 1);
			wrap_up();
		end
		repeat (2) @(posedge sys_clk);
	endtask : idle
	function automatic logic [15:0] merge(logic [1:0] mm, logic [15:0] m, logic [15:0] f,
		logic [15:0] d);
		logic [15:0] r;
		case (mm)
			2'h0: r = d;
			2'h1: r = f | d;
			2'h2: r = f & d;
			default: r = f ^ d;
		endcase
		return (r & m) | (f & ~m);
	endfunction : merge
	// pattern write in one host width, read back in the same or the other width
	task automatic ptnRun(logic bw, logic br, int s, int nw);
		logic [15:0] wd [$];
		repeat (nw) wd.push_back(16'($urandom));
		byteHost <= bw;
		put(16'h1800 | 16'(s));
		put(16'(bw ? 2 * nw : nw));
		foreach (wd[i]) if (bw) begin
			put({8'h00, wd[i][15:8]});
			put({8'h00, wd[i][7:0]});
		end else put(wd[i]);
		idle();
		pushQ.delete();
		byteHost <= br;
		put(16'h1C00 | 16'(s));
		put(16'(br ? 2 * nw : nw));
		idle();
		chk("ptn count", br ? 2 * nw : nw, pushQ.size());
		foreach (wd[i]) if (br) begin
			chk("ptn hi", wd[i][15:8], pushQ[2 * i][7:0]);
			chk("ptn lo", wd[i][7:0], pushQ[2 * i + 1][7:0]);
		end else chk("ptn word", wd[i], pushQ[i]);
	endtask : ptnRun
	task automatic dmaRun(logic [15:0] op, logic [15:0] ax, logic [15:0] ay, logic [19:0] b);
		@(posedge sys_clk);
		rwAddrIn <= b;
		rwScreenIn <= 2'($urandom);
		rwLoad <= 1'b1;
		@(posedge sys_clk);
		rwLoad <= 1'b0;
		takeQ.delete();
		put(op);
		put(ax);
		put(ay);
		idle();
	endtask : dmaRun
	initial begin
		int i, m, n;
		logic [15:0] w, hi, lo, msk;
		logic [7:0] a;
		logic [15:0] old [0:255];
		void'($urandom(32'h6C0B));
		for (i = 0; i < 256; i++)
			fbMem[i] = 16'($urandom);
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		// origin with every screen code, first of all commands
		for (m = 0; m < 4; m++) begin
			hi = {m[1:0], 6'h00, 8'($urandom)};
			lo = 16'($urandom);
			put(16'h0400);
			put(hi);
			put(lo);
			idle();
			chk("drawScreen", m, drawScreen);
			chk("drawAddr", {hi[7:0], lo[15:4]}, drawAddr);
			chk("drawDot", lo[3:0], drawDot);
			chk("curPointer", 0, curPointer);
		end
		// parameter registers, read held off by a full fifo
		for (m = 0; m < 4; m++) begin
			n = m == 0 ? 31 : $urandom_range(2, 30);
			w = 16'($urandom);
			put(16'h0800 | 16'(n));
			put(w);
			pushQ.delete();
			fifoFull <= 1'b1;
			put(16'h0C00 | 16'(n));
			repeat (8) @(posedge sys_clk);
			chk("push while full", 0, pushQ.size());
			fifoFull <= 1'b0;
			idle();
			chk("param", w, pushQ.size() == 1 ? pushQ[0] : 16'hXXXX);
		end
		ptnRun(1'b0, 1'b0, 15, 1);
		ptnRun(1'b0, 1'b0, 3, 0);
		ptnRun(1'b0, 1'b0, $urandom_range(0, 7), $urandom_range(2, 8));
		ptnRun(1'b1, 1'b0, 2, 3);
		ptnRun(1'b1, 1'b1, 9, 4);
		byteHost <= 1'b0;
		put(16'h0801);
		put(16'h0010);
		// four modify modes under a random mask, then a plain write; 3 by 2 words
		for (m = 0; m < 5; m++) begin
			msk = 16'($urandom);
			put(16'h0800);
			put(msk);
			old = fbMem;
			n = xfers;
			slow <= m[0];
			dmaRun(m == 4 ? 16'h2800 : 16'h2C00 | 16'(m), 16'h0002, 16'h0001, 20'(32 + 4 * m));
			chk("dma words", 6, takeQ.size());
			for (i = 0; i < 6; i++) begin
				a = 8'(32 + 4 * m + 16 * (i / 3) + i % 3);
				w = {8'(n + i), ~8'(n + i)} ^ 16'h5A3C;
				chk("dma word", m == 4 ? w : merge(m[1:0], msk, old[a], w), fbMem[a]);
			end
			chk("outside", old[a + 8'h01], fbMem[a + 8'h01]);
			chk("end addr", 20'(32 + 4 * m + 18), fbAddr);
		end
		// read with a negative width scans downwards, read fifo drained first
		pushQ.delete();
		dmaRun(16'h2400, 16'hFFFE, 16'h0000, 20'h00040);
		chk("read words", 3, takeQ.size());
		chk("read pushes", 0, pushQ.size());
		chk("read end", 20'h0003E, fbAddr);
		for (i = 0; i < 3; i++)
			chk("read word", fbMem[8'h40 - 8'(i)], takeQ[i]);
		wrap_up();
	end
endmodule : test_graphics_register_dma_command_unit
